// >>> dscp_port.sv
// Purpose: Serial debug command port: halt entry, command decode, register shift in and out.
// Assumes: Debug serial clock at most processor clock / 8; core answers halt requests.
// Notes:   Serial clock is sampled, not used as a clock; edges are found in the clock domain.

`timescale 1ns/1ps

// Operation
// - Each input bit is sampled at a falling edge of the serial clock.
// - Words shift in most significant bit first.
// - Outside debug state the two shared pins drive the two-bit chip status; here only in normal running, floated while halting and in turnaround gaps.
// - Output bits change at rising edges of the serial clock, most significant bit first.
// - The serial output carries the register chosen by the last command.
// - On entry to debug state the serial output pulses low to ask for a command.
// - After a read command the output pulses low emulation_port data is ready to shift out.
// - After a write command the output pulses low when ready for data and again emulation_port written.
// - Asserting the request makes the core finish its instruction, save state and enter debug.
// - In debug state a request asserted, acknowledged and released resets the controller.
// - Asserting the request wakes the core from stop or wait.
// - A request held at reset release enters debug state directly.
module dscp_port #(
  parameter int DATA_W = dscp_pkg::DATA_BITS
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // Shared data-in / status-low pin
  input  wire logic                       debugInOrStatusLoIn,
  output logic                            debugInOrStatusLoOut,
  output logic                            debugInOrStatusLoOe,
  // Shared clock-in / status-high pin
  input  wire logic                       debugClkOrStatusHiIn,
  output logic                            debugClkOrStatusHiOut,
  output logic                            debugClkOrStatusHiOe,
  // Serial output and request
  output logic                            debugSerialOut,
  input  wire logic                       debugRequestN,
  // Core side
  input  wire logic [1:0]                 chipStatus,
  input  wire logic                       coreHaltAck,
  output logic                            coreHaltReq,
  output logic                            coreWakeReq,
  output logic                            debugActive,
  output logic [dscp_pkg::SEL_W-1:0]      regSel,
  input  wire logic [DATA_W-1:0]          regRdData,
  output logic [DATA_W-1:0]               regWrData,
  output logic                            regWrStb
);

  localparam logic [dscp_pkg::CNT_W-1:0] DATA_LAST = dscp_pkg::CNT_W'(DATA_W - 1);
  localparam logic [dscp_pkg::CNT_W-1:0] CNT_ONE   = dscp_pkg::CNT_W'(1);
  localparam logic [dscp_pkg::TIM_W-1:0] TIM_ONE   = dscp_pkg::TIM_W'(1);

  // ==========================================================
  // Pin synchronisers
  logic sckLvl, dinLvl, reqLvl;

  dscp_sync3 #(.RESET_VAL(dscp_pkg::SCK_RST)) uSck (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn (debugClkOrStatusHiIn),
    .syncOut (sckLvl)
  );

  dscp_sync3 #(.RESET_VAL(dscp_pkg::DIN_RST)) uDin (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn (debugInOrStatusLoIn),
    .syncOut (dinLvl)
  );

  dscp_sync3 #(.RESET_VAL(dscp_pkg::REQ_RST)) uReq (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn (debugRequestN),
    .syncOut (reqLvl)
  );

  // ==========================================================
  // State
  dscp_pkg::dscp_state_type          state_r, state_nxt, ret_r, ret_nxt;
  logic [dscp_pkg::CNT_W-1:0]        bitCnt_r, bitCnt_nxt;
  logic [dscp_pkg::TIM_W-1:0]        tim_r, tim_nxt;
  logic [DATA_W-1:0]                 shift_r, shift_nxt;
  logic [DATA_W-1:0]                 wrData_r, wrData_nxt;
  logic [dscp_pkg::CMD_BITS-1:0]     cmd_r, cmd_nxt;
  logic                              so_r, so_nxt;
  logic                              sckPrev_r, reqPrev_r;
  logic                              boot_r, boot_nxt;
  logic [1:0]                        status_r, status_nxt;
  logic                              oe_r, oe_nxt;
  logic                              wake_r, wake_nxt;
  logic                              wrStb_r, wrStb_nxt;
  logic                              halt_r, halt_nxt;
  logic                              sckFall, sckRise, reqFall, reqRise, inDebug;
  logic                              goAck;
  dscp_pkg::dscp_state_type          ackRet;
  logic [dscp_pkg::CMD_BITS-1:0]     cmdWord;

  // Edge finding; each sampled level lasts several clocks at the 1:8 ratio
  assign sckFall = sckPrev_r & ~sckLvl;
  assign sckRise = ~sckPrev_r & sckLvl;
  assign reqFall = reqPrev_r & ~reqLvl;
  assign reqRise = ~reqPrev_r & reqLvl;
  assign inDebug = (state_r == dscp_pkg::ST_ACK) || (state_r == dscp_pkg::ST_CMD) ||
                   (state_r == dscp_pkg::ST_RDSHIFT) || (state_r == dscp_pkg::ST_WRDATA) ||
                   (state_r == dscp_pkg::ST_DRWAIT);

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_nxt  = state_r;
    ret_nxt    = ret_r;
    bitCnt_nxt = bitCnt_r;
    tim_nxt    = tim_r;
    shift_nxt  = shift_r;
    wrData_nxt = wrData_r;
    cmd_nxt    = cmd_r;
    so_nxt     = so_r;
    boot_nxt   = boot_r;
    wake_nxt   = 1'b0;
    wrStb_nxt  = 1'b0;
    goAck      = 1'b0;
    ackRet     = dscp_pkg::ST_CMD;
    cmdWord    = {cmd_r[dscp_pkg::CMD_BITS-2:0], dinLvl};
    // Count out the request synchroniser latency before deciding how to start
    if (boot_r)
    begin
      tim_nxt = tim_r + TIM_ONE;
    end
    case (state_r)
      dscp_pkg::ST_RUN:
      begin
        if (boot_r)
        begin
          if (tim_r == dscp_pkg::BOOT_LAST)
          begin
            boot_nxt = 1'b0;
            tim_nxt  = '0;
            if (!reqLvl)
              state_nxt = dscp_pkg::ST_GAP_IN;
          end
        end
        else if (reqFall)
        begin
          state_nxt = dscp_pkg::ST_HALT;
          wake_nxt  = 1'b1;
        end
      end
      dscp_pkg::ST_HALT:
      begin
        // Core finishes its instruction and saves its pipeline first
        if (coreHaltAck)
        begin
          state_nxt = dscp_pkg::ST_GAP_IN;
          tim_nxt   = '0;
        end
      end
      dscp_pkg::ST_GAP_IN:
      begin
        tim_nxt = tim_r + TIM_ONE;
        if (tim_r == dscp_pkg::GAP_LAST)
        begin
          goAck  = 1'b1;
          ackRet = dscp_pkg::ST_DRWAIT;
        end
      end
      dscp_pkg::ST_ACK:
      begin
        tim_nxt = tim_r + TIM_ONE;
        if (tim_r == dscp_pkg::ACK_LAST)
        begin
          so_nxt    = dscp_pkg::SO_IDLE;
          state_nxt = ret_r;
          bitCnt_nxt = '0;
        end
      end
      dscp_pkg::ST_DRWAIT:
      begin
        // Commands only count emulation_port the request is released
        if (reqLvl)
        begin
          state_nxt  = dscp_pkg::ST_CMD;
          bitCnt_nxt = '0;
        end
      end
      dscp_pkg::ST_CMD:
      begin
        if (sckFall)
        begin
          cmd_nxt    = cmdWord;
          bitCnt_nxt = bitCnt_r + CNT_ONE;
          if (bitCnt_r == dscp_pkg::CMD_LAST)
          begin
            if (cmdWord[dscp_pkg::CMD_GO_BIT])
            begin
              state_nxt = dscp_pkg::ST_GAP_OUT;
              tim_nxt   = '0;
            end
            else if (cmdWord[dscp_pkg::CMD_READ_BIT])
            begin
              shift_nxt = regRdData;
              goAck     = 1'b1;
              ackRet    = dscp_pkg::ST_RDSHIFT;
            end
            else
            begin
              goAck  = 1'b1;
              ackRet = dscp_pkg::ST_WRDATA;
            end
          end
        end
      end
      dscp_pkg::ST_RDSHIFT:
      begin
        if (sckRise)
        begin
          so_nxt    = shift_r[DATA_W-1];
          shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
        end
        else if (sckFall)
        begin
          bitCnt_nxt = bitCnt_r + CNT_ONE;
          if (bitCnt_r == DATA_LAST)
          begin
            so_nxt     = dscp_pkg::SO_IDLE;
            state_nxt  = dscp_pkg::ST_CMD;
            bitCnt_nxt = '0;
          end
        end
      end
      dscp_pkg::ST_WRDATA:
      begin
        if (sckFall)
        begin
          shift_nxt  = {shift_r[DATA_W-2:0], dinLvl};
          bitCnt_nxt = bitCnt_r + CNT_ONE;
          if (bitCnt_r == DATA_LAST)
          begin
            wrData_nxt = {shift_r[DATA_W-2:0], dinLvl};
            wrStb_nxt  = 1'b1;
            goAck      = 1'b1;
          end
        end
      end
      dscp_pkg::ST_GAP_OUT:
      begin
        tim_nxt = tim_r + TIM_ONE;
        if (tim_r == dscp_pkg::GAP_LAST)
          state_nxt = dscp_pkg::ST_RUN;
      end
      default:
      begin
        state_nxt = dscp_pkg::ST_RUN;
      end
    endcase
    // A fresh request in debug state resynchronises the controller
    if (inDebug && reqFall)
    begin
      goAck  = 1'b1;
      ackRet = dscp_pkg::ST_DRWAIT;
      so_nxt = dscp_pkg::SO_ACK;
    end
    if (goAck)
    begin
      state_nxt = dscp_pkg::ST_ACK;
      ret_nxt   = ackRet;
      so_nxt    = dscp_pkg::SO_ACK;
      tim_nxt   = '0;
    end
    // Pins turn only through a floated gap; status only in normal running
    oe_nxt     = (state_nxt == dscp_pkg::ST_RUN);
    status_nxt = oe_nxt ? chipStatus : status_r;
    halt_nxt   = (state_nxt != dscp_pkg::ST_RUN) || boot_nxt;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r   <= dscp_pkg::ST_RUN;
      ret_r     <= dscp_pkg::ST_CMD;
      bitCnt_r  <= '0;
      tim_r     <= '0;
      shift_r   <= '0;
      wrData_r  <= '0;
      cmd_r     <= '0;
      so_r      <= dscp_pkg::SO_IDLE;
      boot_r    <= 1'b1;
      status_r  <= dscp_pkg::STATUS_RST;
      oe_r      <= 1'b1;
      wake_r    <= 1'b0;
      wrStb_r   <= 1'b0;
      halt_r    <= 1'b1;
      sckPrev_r <= dscp_pkg::SCK_RST;
      reqPrev_r <= dscp_pkg::REQ_RST;
    end
    else
    begin
      state_r   <= state_nxt;
      ret_r     <= ret_nxt;
      bitCnt_r  <= bitCnt_nxt;
      tim_r     <= tim_nxt;
      shift_r   <= shift_nxt;
      wrData_r  <= wrData_nxt;
      cmd_r     <= cmd_nxt;
      so_r      <= so_nxt;
      boot_r    <= boot_nxt;
      status_r  <= status_nxt;
      oe_r      <= oe_nxt;
      wake_r    <= wake_nxt;
      wrStb_r   <= wrStb_nxt;
      halt_r    <= halt_nxt;
      sckPrev_r <= sckLvl;
      reqPrev_r <= reqLvl;
    end
  end

  // Outputs
  assign debugInOrStatusLoOut  = status_r[0];
  assign debugClkOrStatusHiOut = status_r[1];
  assign debugInOrStatusLoOe   = oe_r;
  assign debugClkOrStatusHiOe  = oe_r;
  assign debugSerialOut        = so_r;
  assign coreHaltReq           = halt_r;
  assign coreWakeReq           = wake_r;
  assign debugActive           = inDebug;
  assign regSel                = cmd_r[dscp_pkg::SEL_W-1:0];
  assign regWrData             = wrData_r;
  assign regWrStb              = wrStb_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence ackPulse;
    (state_r == dscp_pkg::ST_ACK && !so_r) [*4] ##1 so_r;
  endsequence

  a_status_drive: assert property (oe_r |-> state_r == dscp_pkg::ST_RUN)
    else $error("status driven outside normal running");
  a_turn_float: assert property ($fell(oe_r) |-> !oe_r [*2])
    else $error("pin not floated through turnaround");
  a_entry_ack: assert property ($rose(state_r == dscp_pkg::ST_ACK) && $past(state_r) == dscp_pkg::ST_GAP_IN
                                |-> ackPulse)
    else $error("entry acknowledge not four clocks low");
  a_in_ignored: assert property (state_r == dscp_pkg::ST_RUN |=> $stable(cmd_r) && $stable(shift_r))
    else $error("serial input taken outside debug state");
  a_shift_fall: assert property (state_r == dscp_pkg::ST_CMD && sckFall |=> cmd_r[0] == $past(dinLvl))
    else $error("command bit not sampled on falling edge");
  a_out_rise: assert property (state_r == dscp_pkg::ST_RDSHIFT && sckRise && !reqFall
                               |=> so_r == $past(shift_r[DATA_W-1]))
    else $error("output bit not driven on rising edge");
  a_read_ack: assert property (state_r == dscp_pkg::ST_CMD && sckFall && bitCnt_r == dscp_pkg::CMD_LAST &&
                               cmdWord[dscp_pkg::CMD_READ_BIT] && !cmdWord[dscp_pkg::CMD_GO_BIT] && !reqFall
                               |=> shift_r == $past(regRdData) ##0 ackPulse)
    else $error("read acknowledge or data missing");
  a_write_done: assert property (wrStb_r |-> state_r == dscp_pkg::ST_ACK && !so_r ##1 !so_r [*3] ##1 so_r)
    else $error("write completion acknowledge missing");
  a_halt_entry: assert property (state_r == dscp_pkg::ST_RUN && !boot_r && reqFall
                                 |=> coreWakeReq && coreHaltReq && state_r == dscp_pkg::ST_HALT)
    else $error("request did not halt and wake core");
  a_dr_resync: assert property (inDebug && reqFall |=> ackPulse ##0 state_r == dscp_pkg::ST_DRWAIT)
    else $error("request did not reset controller");
  a_boot_entry: assert property ($fell(boot_r) && !$past(reqLvl) |-> state_r == dscp_pkg::ST_GAP_IN)
    else $error("request at reset release did not enter debug");

endmodule : dscp_port

// >>> dscp_pkg.sv
// Purpose: Shared constants and types for the debug serial command port.
// Assumes: Processor clock of 20 MHz; debug serial clock at most one eighth of it.
// Notes:   Counts are last-index values so counters compare against them directly.

// ==========================================================
// Package
package dscp_pkg;

  // Serial framing
  localparam int          CMD_BITS     = 8;
  localparam int          DATA_BITS    = 24;
  localparam int          CNT_W        = 5;
  localparam int          SEL_W        = 5;
  localparam int          CMD_READ_BIT = 7;
  localparam int          CMD_GO_BIT   = 6;
  localparam logic [4:0]  CMD_LAST     = 5'h07;

  // Link clock ratio: serial clock no faster than processor clock / 8
  localparam int          CLK_RATIO    = 8;

  // Timing counts in processor clocks
  localparam int          TIM_W        = 3;
  localparam logic [2:0]  ACK_LAST     = 3'h3;  // Acknowledge held low 4 clocks
  localparam logic [2:0]  GAP_LAST     = 3'h1;  // Pins floated 2 clocks on turnaround
  localparam logic [2:0]  BOOT_LAST    = 3'h4;  // Request synchroniser needs 4 clocks; decide on the 5th

  // Reset and idle pin levels
  localparam logic        SO_IDLE      = 1'b1;
  localparam logic        SO_ACK       = 1'b0;
  localparam logic [1:0]  STATUS_RST   = 2'h0;
  localparam logic        SCK_RST      = 1'b0;  // Pulled down externally
  localparam logic        DIN_RST      = 1'b0;
  localparam logic        REQ_RST      = 1'b1;  // Pulled up externally

  // Port controller states
  typedef enum logic [3:0] {
    ST_RUN,
    ST_HALT,
    ST_GAP_IN,
    ST_ACK,
    ST_CMD,
    ST_RDSHIFT,
    ST_WRDATA,
    ST_DRWAIT,
    ST_GAP_OUT
  } dscp_state_type;

endpackage : dscp_pkg

// >>> dscp_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: Input is asynchronous to clock.
// Notes:   Output changes only when stages two and three agree.

`timescale 1ns/1ps

// ==========================================================
// Synchroniser
module dscp_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Pin side
  input  wire logic asyncIn,
  // Clock side
  output logic      syncOut
);

  logic s1_r, s2_r, s3_r, out_r;
  logic out_nxt;

  // Stage one feeds stage two only, to keep metastability contained
  always_comb
  begin
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  // Registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r  <= RESET_VAL;
      s2_r  <= RESET_VAL;
      s3_r  <= RESET_VAL;
      out_r <= RESET_VAL;
    end
    else
    begin
      s1_r  <= asyncIn;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign syncOut = out_r;

endmodule : dscp_sync3

// >>> dscp_ctrl_model.sv
// Purpose: External debug command controller driving the serial link.
// Assumes: Link clock period of 8 processor clocks when sending, 12 when reading data, low between frames.
// Notes:   Lines are released to their pull-downs outside frames.

`timescale 1ns/1ps

// ==========================================================
// Controller model
module dscp_ctrl_model (
  // Pacing clock
  input  wire logic clock,
  // Pins toward the port
  output logic      sckVal,
  output logic      sckOe,
  output logic      sdiVal,
  output logic      sdiOe,
  output logic      debugRequestN,
  // Serial output from the port
  input  wire logic debugSerialOut
);
  // Idle levels at time zero
  initial
  begin
    sckVal = 1'b0;
    sckOe = 1'b0;
    sdiVal = 1'b0;
    sdiOe = 1'b0;
    debugRequestN = 1'b1;
  end

  // Changes land just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Request level; released only after the acknowledge
  task automatic setReq(input logic lvl);
    tick(1);
    debugRequestN = lvl;
  endtask : setReq

  // One bit, period 8 clocks, data set while clock low
  task automatic sendBit(input logic b);
    sdiOe = 1'b1;
    sckOe = 1'b1;
    sdiVal = b;
    tick(2);
    sckVal = 1'b1;
    tick(4);
    sckVal = 1'b0;
    tick(2);
  endtask : sendBit

  // Frame end: let pull-downs take the lines
  task automatic release_lines();
    sdiOe = 1'b0;
    sckOe = 1'b0;
  endtask : release_lines

  task automatic sendCmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) sendBit(c[i]);
    release_lines();
  endtask : sendCmd

  task automatic sendData(input logic [23:0] d);
    for (int i = 23; i >= 0; i--) sendBit(d[i]);
    release_lines();
  endtask : sendData

  // Long high phase so the last bit is seen before the closing fall
  task automatic recvData(output logic [23:0] d);
    sckOe = 1'b1;
    for (int i = 23; i >= 0; i--)
    begin
      sckVal = 1'b1;
      tick(6);
      d[i] = debugSerialOut;
      tick(2);
      sckVal = 1'b0;
      tick(4);
    end
    release_lines();
  endtask : recvData
endmodule : dscp_ctrl_model

// >>> dscp_port_bench.sv
// Purpose: Self-checking bench for the debug serial command port.
// Assumes: 20 MHz clock; controller model paces the link.
// Notes:   Shared pins are resolved here with their pull-downs.

`timescale 1ns/1ps

// ==========================================================
// Bench
module dscp_port_bench;
  logic clock;
  logic rstn;
  logic loOut, loOe, hiOut, hiOe, loPin, hiPin, serialOut;
  logic sckVal, sckOe, sdiVal, sdiOe, reqN;
  logic [1:0] chipStatus;
  logic coreHaltAck;
  logic coreHaltReq, coreWakeReq, debugActive, regWrStb;
  logic [4:0] regSel;
  logic [23:0] regRdData;
  logic [23:0] regWrData, wrSeen, rdSeen;
  int miscompares = 0;
  int checks_done = 0;
  int wakeCnt = 0;
  int wrCnt = 0;
  logic floatSeen = 1'b0;

  always #25 clock = ~clock;

  // Pin levels: device, else controller, else pull-down
  assign loPin = loOe ? loOut : (sdiOe ? sdiVal : 1'b0);
  assign hiPin = hiOe ? hiOut : (sckOe ? sckVal : 1'b0);

  dscp_port dscp_port_i (
    .clock(clock), .rstn(rstn),
    .debugInOrStatusLoIn(loPin), .debugInOrStatusLoOut(loOut), .debugInOrStatusLoOe(loOe),
    .debugClkOrStatusHiIn(hiPin), .debugClkOrStatusHiOut(hiOut), .debugClkOrStatusHiOe(hiOe),
    .debugSerialOut(serialOut), .debugRequestN(reqN),
    .chipStatus(chipStatus), .coreHaltAck(coreHaltAck), .coreHaltReq(coreHaltReq),
    .coreWakeReq(coreWakeReq), .debugActive(debugActive), .regSel(regSel),
    .regRdData(regRdData), .regWrData(regWrData), .regWrStb(regWrStb)
  );

  dscp_ctrl_model dscp_ctrl_model_i (
    .clock(clock), .sckVal(sckVal), .sckOe(sckOe), .sdiVal(sdiVal), .sdiOe(sdiOe),
    .debugRequestN(reqN), .debugSerialOut(serialOut)
  );

  // Event monitors: wake pulses, write strobes, floated turnarounds
  always @(posedge clock)
  begin
    if (coreWakeReq === 1'b1) wakeCnt++;
    if (regWrStb === 1'b1) wrCnt++;
    if (regWrStb === 1'b1) wrSeen = regWrData;
    if (loOe === 1'b0 && hiOe === 1'b0) floatSeen = 1'b1;
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Acknowledge must come in bounded time and stay low exactly 4 clocks
  task automatic waitAck(input string what);
    int n;
    int lowLen;
    n = 0;
    lowLen = 0;
    while (serialOut !== 1'b0 && n < 600)
    begin
      dscp_ctrl_model_i.tick(1);
      n++;
    end
    while (serialOut === 1'b0 && lowLen < 20)
    begin
      dscp_ctrl_model_i.tick(1);
      lowLen++;
    end
    chk(what, 24'(lowLen), 24'h000004);
  endtask : waitAck

  task automatic test_run();
    chipStatus = 2'h2;
    dscp_ctrl_model_i.tick(12);
    chk("status pins driven", {loOe, hiOe}, 24'h000003);
    chk("status pin values", {hiOut, loOut}, 24'h000002);
    chk("halt low in run", coreHaltReq, 24'h000000);
    $display("test_run done");
  endtask : test_run

  task automatic test_enter();
    floatSeen = 1'b0;
    dscp_ctrl_model_i.setReq(1'b0);
    dscp_ctrl_model_i.tick(12);
    chk("no ack before halt", serialOut, 24'h000001);
    chk("wake pulse", 24'(wakeCnt), 24'h000001);
    coreHaltAck = 1'b1;
    waitAck("entry ack");
    coreHaltAck = 1'b0;
    chk("pins floated on entry", floatSeen, 24'h000001);
    chk("debug active", {debugActive, coreHaltReq}, 24'h000003);
    dscp_ctrl_model_i.setReq(1'b1);
    dscp_ctrl_model_i.tick(6);
    $display("test_enter done");
  endtask : test_enter

  task automatic test_read(input logic [4:0] sel, input logic [23:0] d);
    regRdData = d;
    dscp_ctrl_model_i.sendCmd({3'b100, sel});
    waitAck("read ack");
    chk("read select", regSel, 24'(sel));
    regRdData = ~d;
    dscp_ctrl_model_i.recvData(rdSeen);
    chk("read data", rdSeen, d);
    dscp_ctrl_model_i.tick(8);
    $display("test_read done");
  endtask : test_read

  task automatic test_write(input logic [4:0] sel, input logic [23:0] d);
    wrCnt = 0;
    dscp_ctrl_model_i.sendCmd({3'b000, sel});
    waitAck("write ready ack");
    dscp_ctrl_model_i.sendData(d);
    waitAck("write done ack");
    chk("write strobes", 24'(wrCnt), 24'h000001);
    chk("write data", wrSeen, d);
    chk("write select", regSel, 24'(sel));
    $display("test_write done");
  endtask : test_write

  // Three bits of a command, then the request recovers the controller
  task automatic test_resync();
    dscp_ctrl_model_i.sendBit(1'b1);
    dscp_ctrl_model_i.sendBit(1'b0);
    dscp_ctrl_model_i.sendBit(1'b1);
    dscp_ctrl_model_i.release_lines();
    dscp_ctrl_model_i.setReq(1'b0);
    waitAck("resync ack");
    dscp_ctrl_model_i.setReq(1'b1);
    dscp_ctrl_model_i.tick(6);
    test_read(5'h1F, 24'h3C5AA5);
    $display("test_resync done");
  endtask : test_resync

  task automatic test_leave();
    int n;
    floatSeen = 1'b0;
    n = 0;
    dscp_ctrl_model_i.sendCmd(8'h40);
    while (loOe !== 1'b1 && n < 60)
    begin
      dscp_ctrl_model_i.tick(1);
      n++;
    end
    chipStatus = 2'h1;
    dscp_ctrl_model_i.tick(3);
    chk("float on exit", floatSeen, 24'h000001);
    // Last fall acted on three clocks after release, then two floated clocks
    chk("float length on exit", 24'(n), 24'h000005);
    chk("run after exit", {debugActive, coreHaltReq}, 24'h000000);
    chk("status after exit", {hiOe, loOe, hiOut, loOut}, 24'h00000D);
    $display("test_leave done");
  endtask : test_leave

  // Request held through reset release enters debug without a halt handshake
  task automatic test_boot_debug();
    dscp_ctrl_model_i.setReq(1'b0);
    rstn = 1'b0;
    dscp_ctrl_model_i.tick(4);
    rstn = 1'b1;
    waitAck("boot ack");
    chk("boot debug", {debugActive, coreHaltReq}, 24'h000003);
    dscp_ctrl_model_i.setReq(1'b1);
    $display("test_boot_debug done");
  endtask : test_boot_debug

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Watchdog: tests need under two thousand clocks
  initial
  begin
    #2000000;
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    clock = 1'b0;
    rstn = 1'b0;
    chipStatus = 2'h0;
    coreHaltAck = 1'b0;
    regRdData = 24'h000000;
    dscp_ctrl_model_i.tick(8);
    chk("reset pins", {loOe, hiOe, loOut, hiOut, serialOut}, 24'h000019);
    rstn = 1'b1;
    test_run();
    test_enter();
    test_read(5'h0A, 24'hA5C3F1);
    test_read(5'h15, 24'h5A3C0E);
    test_write(5'h11, 24'h96F00F);
    test_resync();
    test_leave();
    test_boot_debug();
    end_sim();
  end
endmodule : dscp_port_bench
